//--- ufbg_channel.sv
// One channel: prescaler plus integer/fractional rate divider
`timescale 1ns/100ps
`default_nettype none
module ufbg_channel
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Oscillator tick, one cycle per osc_input rising edge
  input  wire logic        osc_tick,
  // Configuration
  input  wire logic [7:0]  modem_ctrl_reg,
  input  wire logic [7:0]  divisor_low,
  input  wire logic [7:0]  divisor_high,
  input  wire logic [7:0]  divisor_fraction,
  // Outputs
  output logic             sample_tick,
  output logic             bit_tick,
  output logic [1:0]       ratio_sel
);

  logic [1:0]  pre_cnt_ff;
  logic [1:0]  nxt_pre_cnt;
  logic [15:0] div_cnt_ff;
  logic [15:0] nxt_div_cnt;
  logic [3:0]  frac_acc_ff;
  logic [3:0]  nxt_frac_acc;
  logic        stretch_ff;
  logic        nxt_stretch;
  logic        sample_ff;
  logic        nxt_sample;
  logic [4:0]  bit_cnt_ff;
  logic [4:0]  nxt_bit_cnt;
  logic        bit_ff;
  logic        nxt_bit;

  wire         prescale_on = modem_ctrl_reg[ufbg_pkg::PRESCALE_BIT];
  wire [15:0]  div_int     = {divisor_high, divisor_low};
  wire [3:0]   div_frac    = divisor_fraction[ufbg_pkg::FRAC_LSB +: ufbg_pkg::DIV_FRAC_W];
  wire [1:0]   ratio       = divisor_fraction[ufbg_pkg::RATIO_LSB +: ufbg_pkg::RATIO_W];
  // Divisor zero is treated as one so the output never stalls
  wire [15:0]  div_eff     = (div_int == 16'h0000) ? 16'h0001 : div_int;
  wire         pre_last    = !prescale_on || (pre_cnt_ff == ufbg_pkg::PRESCALE_LAST);
  wire         pre_tick    = osc_tick && pre_last;
  wire         period_end  = pre_tick && (div_cnt_ff >= div_eff - 16'h0001) &&
                             (!stretch_ff || div_cnt_ff >= div_eff);
  wire [4:0]   acc_sum     = {1'b0, frac_acc_ff} + {1'b0, div_frac};
  wire [4:0]   ticks_per_bit = (ratio == ufbg_pkg::UFBG_RATIO_8X) ? ufbg_pkg::TICKS_8X :
                               (ratio == ufbg_pkg::UFBG_RATIO_4X) ? ufbg_pkg::TICKS_4X :
                               ufbg_pkg::TICKS_16X;

  always_comb
  begin
    nxt_pre_cnt  = pre_cnt_ff;
    nxt_div_cnt  = div_cnt_ff;
    nxt_frac_acc = frac_acc_ff;
    nxt_stretch  = stretch_ff;
    nxt_sample   = 1'b0;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_bit      = 1'b0;
    if (osc_tick)
    begin
      nxt_pre_cnt = pre_last ? 2'h0 : pre_cnt_ff + 2'h1;
    end
    if (pre_tick)
    begin
      if (period_end)
      begin
        nxt_div_cnt  = 16'h0000;
        nxt_frac_acc = acc_sum[3:0];
        nxt_stretch  = acc_sum[4];
        nxt_sample   = 1'b1;
        // In 8X with an odd fraction the stretch lands unevenly per bit
        if (bit_cnt_ff >= ticks_per_bit - 5'h01)
        begin
          nxt_bit_cnt = 5'h00;
          nxt_bit     = 1'b1;
        end
        else
        begin
          nxt_bit_cnt = bit_cnt_ff + 5'h01;
        end
      end
      else
      begin
        nxt_div_cnt = div_cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pre_cnt_ff  <= 2'h0;
      div_cnt_ff  <= 16'h0000;
      frac_acc_ff <= 4'h0;
      stretch_ff  <= 1'b0;
      sample_ff   <= 1'b0;
      bit_cnt_ff  <= 5'h00;
      bit_ff      <= 1'b0;
    end
    else
    begin
      pre_cnt_ff  <= nxt_pre_cnt;
      div_cnt_ff  <= nxt_div_cnt;
      frac_acc_ff <= nxt_frac_acc;
      stretch_ff  <= nxt_stretch;
      sample_ff   <= nxt_sample;
      bit_cnt_ff  <= nxt_bit_cnt;
      bit_ff      <= nxt_bit;
    end
  end

  assign sample_tick = sample_ff;
  assign bit_tick    = bit_ff;
  assign ratio_sel   = ratio;

endmodule : ufbg_channel
`default_nettype wire

//--- ufbg_pkg.sv
// Package with constants for the fractional sampling-clock generator
`default_nettype none
package ufbg_pkg;

  localparam int unsigned DIV_INT_W   = 16;
  localparam int unsigned DIV_FRAC_W  = 4;
  localparam int unsigned BYTE_W      = 8;

  // Register field positions
  localparam int unsigned PRESCALE_BIT = 7;
  localparam int unsigned FRAC_LSB     = 0;
  localparam int unsigned RATIO_LSB    = 4;
  localparam int unsigned RATIO_W      = 2;

  // Register offsets on the write and read ports
  localparam logic [1:0] ADDR_LOW      = 2'h0;
  localparam logic [1:0] ADDR_HIGH     = 2'h1;
  localparam logic [1:0] ADDR_FRAC     = 2'h2;
  localparam logic [1:0] ADDR_MODEM    = 2'h3;

  // Values after reset
  localparam logic [7:0] DIV_LOW_RST   = 8'h01;
  localparam logic [7:0] DIV_HIGH_RST  = 8'h00;
  localparam logic [7:0] DIV_FRAC_RST  = 8'h00;
  localparam logic [7:0] MODEM_RST     = 8'h00;

  // Last prescaler count when enabled; the prescaler divides by 4
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // Sampling ratio encodings
  typedef enum logic [1:0]
  {
    UFBG_RATIO_16X = 2'b00,
    UFBG_RATIO_8X  = 2'b01,
    UFBG_RATIO_4X  = 2'b10
  } ufbg_ratio_t;

  // Sample-clock ticks per serial bit for each ratio
  localparam logic [4:0] TICKS_16X = 5'h10;
  localparam logic [4:0] TICKS_8X  = 5'h08;
  localparam logic [4:0] TICKS_4X  = 5'h04;

  // Identification code; value is arbitrary
  localparam logic [7:0] DEVICE_ID = 8'h5a;

endpackage : ufbg_pkg
`default_nettype wire

//--- ufbg_props.sv
// Checker of the sampling-clock generator ports
`timescale 1ns/100ps
`default_nettype none
module ufbg_props
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Oscillator
  input wire logic       osc_input,
  input wire logic       osc_output,
  // Register port
  input wire logic [1:0] chan_sel,
  input wire logic       reg_wr,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       rd_chan,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] device_id,
  // Sampling outputs
  input wire logic [1:0] sample_tick,
  input wire logic [1:0] bit_tick,
  input wire logic [3:0] ratio_sel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr0(logic [1:0] a);
    reg_wr && chan_sel[0] && reg_addr == a;
  endsequence
  sequence s_rd0(logic [1:0] a);
    !reg_wr && !rd_chan && reg_addr == a;
  endsequence
  AST_RD_LOW: assert property (s_wr0(2'h0) ##1 s_rd0(2'h0) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("divisor low readback wrong");
  AST_RD_HIGH: assert property (s_wr0(2'h1) ##1 s_rd0(2'h1) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("divisor high readback wrong");
  AST_FRAC_MASK: assert property (s_wr0(2'h2) ##1 s_rd0(2'h2) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f))
    else $error("fraction readback wrong");
  AST_RATIO: assert property (s_wr0(2'h2) |=> {2'h0, ratio_sel[1:0], 4'h0} == ($past(reg_wdata) & 8'h30))
    else $error("ratio select not taken");
  AST_CH_INDEP: assert property (reg_wr && chan_sel == 2'h1 |=> $stable(ratio_sel[3:2]))
    else $error("other channel disturbed");
  AST_BIT_SAMPLE0: assert property (bit_tick[0] |-> sample_tick[0])
    else $error("bit tick without sample tick");
  AST_BIT_SAMPLE1: assert property (bit_tick[1] |-> sample_tick[1])
    else $error("bit tick without sample tick");
  AST_SAMPLE_PULSE: assert property (sample_tick[0] |=> !sample_tick[0])
    else $error("sample tick too long");
  AST_BIT_GAP: assert property (bit_tick[0] |=> !bit_tick[0] [*7])
    else $error("bit ticks too close");
endmodule : ufbg_props
bind ufbg_top ufbg_props i_ufbg_props (.sys_clk(sys_clk), .rst_n(rst_n), .osc_input(osc_input),
  .osc_output(osc_output), .chan_sel(chan_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .rd_chan(rd_chan), .reg_rdata(reg_rdata), .device_id(device_id), .sample_tick(sample_tick),
  .bit_tick(bit_tick), .ratio_sel(ratio_sel));
`default_nettype wire

//--- ufbg_top.sv
// Dual-channel fractional sampling-clock generator with divisor registers
`timescale 1ns/100ps
`default_nettype none
module ufbg_top
#(
  parameter int unsigned NUM_CH = 2
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Oscillator pin, asynchronous to sys_clk
  input  wire logic              osc_input,
  output logic                   osc_output,
  // Register write port, on sys_clk
  input  wire logic [NUM_CH-1:0] chan_sel,
  input  wire logic              reg_wr,
  input  wire logic [1:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  // Register read port
  input  wire logic              rd_chan,
  output logic [7:0]             reg_rdata,
  output logic [7:0]             device_id,
  // Sampling outputs per channel
  output logic [NUM_CH-1:0]      sample_tick,
  output logic [NUM_CH-1:0]      bit_tick,
  output logic [2*NUM_CH-1:0]    ratio_sel
);

  logic osc_meta_ff;
  logic osc_sync_ff;
  logic osc_prev_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  logic [7:0] low_q  [NUM_CH];
  logic [7:0] high_q [NUM_CH];
  logic [7:0] frac_q [NUM_CH];
  logic [7:0] modem_q [NUM_CH];

  // Oscillator pin passes two flops; the edge detect compares the second one with a third flop
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end
    else
    begin
      osc_meta_ff <= osc_input;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  wire osc_tick = osc_sync_ff && !osc_prev_ff;

  // Registers are written by sys_clk, so access never waits on the oscillator
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic [7:0] low_ff;
      logic [7:0] high_ff;
      logic [7:0] frac_ff;
      logic [7:0] modem_ff;
      wire        wr_here = reg_wr && chan_sel[ch];

      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          low_ff   <= ufbg_pkg::DIV_LOW_RST;
          high_ff  <= ufbg_pkg::DIV_HIGH_RST;
          frac_ff  <= ufbg_pkg::DIV_FRAC_RST;
          modem_ff <= ufbg_pkg::MODEM_RST;
        end
        else if (wr_here)
        begin
          if (reg_addr == ufbg_pkg::ADDR_LOW)
            low_ff <= reg_wdata;
          if (reg_addr == ufbg_pkg::ADDR_HIGH)
            high_ff <= reg_wdata;
          if (reg_addr == ufbg_pkg::ADDR_FRAC)
            frac_ff <= {2'b00, reg_wdata[5:0]};
          if (reg_addr == ufbg_pkg::ADDR_MODEM)
            modem_ff <= reg_wdata;
        end
      end

      assign low_q[ch]   = low_ff;
      assign high_q[ch]  = high_ff;
      assign frac_q[ch]  = frac_ff;
      assign modem_q[ch] = modem_ff;

      ufbg_channel u_gen
      (
        .sys_clk          (sys_clk),
        .rst_n            (rst_n),
        .osc_tick         (osc_tick),
        .modem_ctrl_reg   (modem_ff),
        .divisor_low      (low_ff),
        .divisor_high     (high_ff),
        .divisor_fraction (frac_ff),
        .sample_tick      (sample_tick[ch]),
        .bit_tick         (bit_tick[ch]),
        .ratio_sel        (ratio_sel[2*ch +: 2])
      );
    end
  endgenerate

  wire       rd_idx = rd_chan;
  wire [7:0] rd_mux = (reg_addr == ufbg_pkg::ADDR_LOW)  ? low_q[rd_idx]  :
                      (reg_addr == ufbg_pkg::ADDR_HIGH) ? high_q[rd_idx] :
                      (reg_addr == ufbg_pkg::ADDR_FRAC) ? frac_q[rd_idx] :
                      modem_q[rd_idx];

  always_comb
  begin
    nxt_rdata = rd_mux;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata  = rdata_ff;
  assign device_id  = ufbg_pkg::DEVICE_ID;
  // Inverted oscillator output; real crystal drive is analog
  assign osc_output = ~osc_input;

endmodule : ufbg_top
`default_nettype wire

//--- ufbg_top_tb.sv
// Self-checking bench for the sampling-clock generator
`timescale 1ns/100ps
`default_nettype none
module ufbg_top_tb;
  logic            sys_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            osc_input = 1'b0;
  logic            osc_en = 1'b0;
  logic [1:0]      chan_sel = 2'h0;
  logic            reg_wr = 1'b0;
  logic [1:0]      reg_addr = 2'h0;
  logic [7:0]      reg_wdata = 8'h00;
  logic            rd_chan = 1'b0;
  wire logic [7:0] reg_rdata;
  wire logic [7:0] device_id;
  wire logic [1:0] sample_tick;
  wire logic [1:0] bit_tick;
  wire logic [3:0] ratio_sel;
  wire logic       osc_output;
  int              fails = 0;
  int              samples_checked = 0;
  always #12.5 sys_clk = ~sys_clk;
  // Oscillator edges fall mid-cycle, so each osc period is exactly 4 clocks
  always #50 if (osc_en) osc_input = ~osc_input;
  ufbg_top i_ufbg_top (.sys_clk(sys_clk), .rst_n(rst_n), .osc_input(osc_input), .osc_output(osc_output),
    .chan_sel(chan_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_chan(rd_chan),
    .reg_rdata(reg_rdata), .device_id(device_id), .sample_tick(sample_tick), .bit_tick(bit_tick),
    .ratio_sel(ratio_sel));
  task automatic print_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] cs, input logic [1:0] a, input logic [7:0] d);
    chan_sel = cs;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
    // One idle edge keeps back-to-back writes from retoggling the strobe in one step
    @(posedge sys_clk);
    #1;
  endtask : wr
  task automatic rd(input logic ch, input logic [1:0] a, input logic [7:0] exp);
    rd_chan = ch;
    reg_addr = a;
    @(posedge sys_clk);
    #1 chk(reg_rdata, exp);
  endtask : rd
  // Program one channel, then time 16 sample periods and one bit span
  task automatic run(input logic ch, input int dv, input int fr, input int rt, input int pre, input int n);
    logic [1:0] cs;
    int         c;
    int         s;
    int         nb;
    int         cyc;
    cs = ch ? 2'h2 : 2'h1;
    c = 0;
    s = 0;
    nb = 0;
    cyc = 0;
    wr(cs, 2'h0, dv[7:0]);
    wr(cs, 2'h1, dv[15:8]);
    wr(cs, 2'h2, {2'h0, rt[1:0], fr[3:0]});
    wr(cs, 2'h3, {pre[0], 7'h00});
    // Two bit ticks let an old count finish before timing starts
    repeat (2)
    begin
      @(posedge sys_clk);
      #1 c++;
      while (bit_tick[ch] !== 1'b1 && c < 20000)
      begin
        @(posedge sys_clk);
        #1 c++;
      end
    end
    c = 0;
    while ((s < 16 || nb == 0) && c < 20000)
    begin
      @(posedge sys_clk);
      #1 c++;
      if (sample_tick[ch] === 1'b1) s++;
      if (bit_tick[ch] === 1'b1 && nb == 0) nb = s;
      if (s == 16 && cyc == 0) cyc = c;
    end
    if (c >= 20000)
    begin
      fails++;
      print_verdict();
    end
    else
    begin
      chk(cyc, 4 * (16 * dv + fr) * (pre != 0 ? 4 : 1));
      chk(nb, n);
    end
  endtask : run
  initial
  begin
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 8; i++) rd(i[2], i[1:0], {7'h00, i[1:0] == 2'h0});
    chk(ratio_sel, 4'h0);
    wr(2'h1, 2'h2, 8'hdf);
    rd(1'b0, 2'h2, 8'h1f);
    chk(ratio_sel, 4'h1);
    wr(2'h2, 2'h1, 8'ha5);
    rd(1'b1, 2'h1, 8'ha5);
    rd(1'b0, 2'h1, 8'h00);
    chk(device_id, ufbg_pkg::DEVICE_ID);
    chk(osc_output, 1'b1);
    wr(2'h3, 2'h0, 8'h3c);
    rd(1'b1, 2'h0, 8'h3c);
    rd(1'b0, 2'h0, 8'h3c);
    wr(2'h1, 2'h1, 8'h96);
    rd(1'b0, 2'h1, 8'h96);
    osc_en = 1'b1;
    run(1'b0, 3, 0, 0, 0, 16);
    run(1'b1, 2, 5, 1, 0, 8);
    run(1'b0, 1, 0, 2, 1, 4);
    run(1'b1, 5, 15, 0, 0, 16);
    run(1'b0, 2, 8, 0, 1, 16);
    print_verdict();
  end
endmodule : ufbg_top_tb
`default_nettype wire
